// ### logic/dag_defs.svh
// Field positions, codes, offsets and reset values of the data address generator
`ifndef DAG_DEFS_SVH
`define DAG_DEFS_SVH

// ==========================================================
// Instruction word fields
`define MODE_BIT          7
`define OFFSET_MSB        6
`define INDEX_SELECT_BIT  6
`define STEP_MSB          6
`define STEP_LSB          4
`define POINTER_LOAD_BIT  3
`define NEXT_PTR_MSB      2

// ==========================================================
// Post-modify codes of bits 6..4
`define STEP_NONE         3'h0
`define STEP_MINUS_ONE    3'h1
`define STEP_PLUS_ONE     3'h2
`define STEP_RESERVED     3'h3
`define STEP_MINUS_IDX_BR 3'h4
`define STEP_MINUS_IDX    3'h5
`define STEP_PLUS_IDX     3'h6
`define STEP_PLUS_IDX_BR  3'h7

// ==========================================================
// Register port offsets
`define OFS_AUX_LAST      4'h7
`define OFS_PAGE          4'h8
`define OFS_POINTER       4'h9

// ==========================================================
// Reset values
`define AUX_RESET         16'h0000
`define PTR_RESET         3'h0
`define ADDR_RESET        16'h0000
`define ZERO_BYTE         8'h00

`endif

// ### logic/dag_pkg.sv
// Types shared by the data address generator
package dag_pkg;

   // Operand class of the instruction being executed
   typedef enum logic [1:0] {
      CLASS_MEMORY    = 2'h0,
      CLASS_BRANCH    = 2'h1,
      CLASS_IMMEDIATE = 2'h2,
      CLASS_NONE      = 2'h3
   } op_class_t;

   // Auxiliary register commands from the decoder
   typedef enum logic [2:0] {
      CMD_NONE                 = 3'h0,
      CMD_LOAD_AUX_FROM_MEMORY = 3'h1,
      CMD_LOAD_AUX_SHORT_IMM   = 3'h2,
      CMD_LOAD_AUX_LONG_IMM    = 3'h3,
      CMD_ADD_AUX_SHORT_IMM    = 3'h4,
      CMD_SUB_AUX_SHORT_IMM    = 3'h5,
      CMD_LOAD_PAGE_SHORT_IMM  = 3'h6,
      CMD_MODIFY_ONLY_OP       = 3'h7
   } aux_cmd_t;

endpackage

// ### logic/data_address_generator.sv
// Data memory address generator with page pointer and auxiliary registers
//
// Function
// - A direct address is the 9-bit page pointer placed above the 7-bit instruction offset.
// - Bits 15..8 are opcode, and bit 7 low selects direct mode with bits 6..0 as offset.
// - Bit 7 high selects indirect mode with bits 6..0 as auxiliary control fields.
// - The page pointer has no reset and is undefined until loaded.
// - Eight auxiliary registers exist and a 3-bit pointer picks the current one.
// - The auxiliary unit does 16-bit unsigned arithmetic within the instruction's cycle.
// - An indirect address is the whole 16-bit content of the current auxiliary register.
// - A step is applied after the old value was issued as the address; a modify-only op steps without issuing one.
// - Bit 6 low steps by one, bit 6 high steps by the index register.
// - Bits 6..4 pick none, -1, +1, reserved, -idx rev, -idx, +idx, +idx rev.
// - Reverse-carry steps carry from the top bit toward the bottom bit.
// - Aux registers load from memory, short or long immediates, step by short immediates.
// - Direct mode excludes branch, immediate and no-operand; indirect excludes the last two.
// - Bit 3 high loads bits 2..0 into the pointer, bit 3 low keeps it.
`timescale 1ns/1ps
`include "dag_defs.svh"

module data_address_generator (
   input  wire logic               ref_clk,          // Core clock, 200 MHz
   input  wire logic               arst_n,           // Asynchronous reset, active low
   input  wire logic               instr_valid,      // Instruction executes this cycle
   input  wire logic [15:0]        instr_word,       // Instruction word from decoder
   input  wire dag_pkg::op_class_t op_class,         // Operand class of the instruction
   input  wire dag_pkg::aux_cmd_t  aux_cmd,          // Auxiliary register command
   input  wire logic [2:0]         aux_sel,          // Target register of an aux command
   input  wire logic [15:0]        operand,          // Memory word or immediate constant
   input  wire logic [3:0]         reg_addr,         // Register port address
   input  wire logic [15:0]        reg_wdata,        // Register port write data
   input  wire logic               reg_wr,           // Register port write strobe
   input  wire logic               reg_rd,           // Register port read strobe
   output logic      [15:0]        reg_rdata,        // Read data, cycle after the strobe
   output logic      [15:0]        data_addr,        // Data memory address
   output logic                    addr_valid,       // Data address issued, one cycle
   output logic                    addr_indirect,    // Issued address was indirect
   output logic                    mode_error,       // Direct mode used with a branch operand
   output logic      [2:0]         aux_reg_pointer   // Current auxiliary register pointer
);
   import dag_pkg::*;

   // ==========================================================
   // Storage
   logic [15:0] aux_register [8];
   logic [15:0] aux_nxt [8];
   logic [8:0]  data_page_pointer_r;
   logic [2:0]  aux_reg_pointer_r;
   logic [15:0] data_addr_r;
   logic        addr_valid_r;
   logic        addr_indirect_r;
   logic        mode_error_r;
   logic [15:0] reg_rdata_r;

   // ==========================================================
   // Instruction decode
   logic        is_indirect;
   logic [6:0]  page_offset;
   logic [2:0]  step_code;
   logic        index_select_bit;
   logic        pointer_load_bit;
   logic [2:0]  next_pointer;
   logic        direct_ok;
   logic        indirect_ok;
   logic        modify_only_op;
   logic        addr_use;
   logic        issue;
   logic        modify_en;
   logic        pointer_en;

   assign is_indirect      = instr_word[`MODE_BIT];
   assign page_offset      = instr_word[`OFFSET_MSB:0];
   assign step_code        = instr_word[`STEP_MSB:`STEP_LSB];
   assign index_select_bit = instr_word[`INDEX_SELECT_BIT];
   assign pointer_load_bit = instr_word[`POINTER_LOAD_BIT];
   assign next_pointer     = instr_word[`NEXT_PTR_MSB:0];

   // Direct only for memory operands, indirect also for branches
   assign direct_ok      = (op_class == CLASS_MEMORY);
   assign indirect_ok    = (op_class == CLASS_MEMORY) ||
                           (op_class == CLASS_BRANCH);
   assign modify_only_op = (aux_cmd == CMD_MODIFY_ONLY_OP);
   assign addr_use       = instr_valid && (is_indirect ? indirect_ok : direct_ok);
   assign issue          = addr_use && !modify_only_op;
   assign modify_en      = instr_valid && is_indirect &&
                           (indirect_ok || modify_only_op);
   assign pointer_en     = modify_en && pointer_load_bit;

   // ==========================================================
   // Auxiliary math unit
   logic [15:0] cur_value;
   logic [15:0] index_value;
   logic [15:0] cur_rev;
   logic [15:0] index_rev;
   logic [15:0] rev_sum;
   logic [15:0] rev_diff;
   logic [15:0] sum_br;
   logic [15:0] diff_br;
   logic [15:0] stepped;
   logic [15:0] short_imm;

   assign cur_value   = aux_register[aux_reg_pointer_r];
   assign index_value = aux_register[0];
   assign short_imm   = {`ZERO_BYTE, operand[7:0]};

   // Reverse the operands so a normal adder carries from the top bit down
   genvar b;
   generate
      for (b = 0; b < 16; b++) begin : g_rev
         assign cur_rev[b]   = cur_value[15 - b];
         assign index_rev[b] = index_value[15 - b];
         assign sum_br[b]    = rev_sum[15 - b];
         assign diff_br[b]   = rev_diff[15 - b];
      end
   endgenerate

   assign rev_sum  = cur_rev + index_rev;
   assign rev_diff = cur_rev - index_rev;

   always_comb begin
      case (step_code)
         `STEP_NONE:         stepped = cur_value;
         `STEP_MINUS_ONE:    stepped = cur_value - 16'h0001;
         `STEP_PLUS_ONE:     stepped = cur_value + 16'h0001;
         `STEP_RESERVED:     stepped = cur_value;
         `STEP_MINUS_IDX_BR: stepped = diff_br;
         `STEP_MINUS_IDX:    stepped = cur_value - index_value;
         `STEP_PLUS_IDX:     stepped = cur_value + index_value;
         `STEP_PLUS_IDX_BR:  stepped = sum_br;
         default:            stepped = cur_value;
      endcase
   end

   // ==========================================================
   // Auxiliary registers
   // Explicit loads win over a post-modify, which wins over the port
   genvar k;
   generate
      for (k = 0; k < 8; k++) begin : g_aux
         logic hit_cmd;
         logic hit_mod;
         logic hit_port;

         assign hit_cmd  = instr_valid && (aux_sel == 3'(k));
         assign hit_mod  = modify_en && (aux_reg_pointer_r == 3'(k));
         assign hit_port = reg_wr && (reg_addr == 4'(k));

         always_comb begin
            aux_nxt[k] = aux_register[k];
            if (hit_cmd && (aux_cmd == CMD_LOAD_AUX_FROM_MEMORY)) begin
               aux_nxt[k] = operand;
            end else if (hit_cmd && (aux_cmd == CMD_LOAD_AUX_SHORT_IMM)) begin
               aux_nxt[k] = short_imm;
            end else if (hit_cmd && (aux_cmd == CMD_LOAD_AUX_LONG_IMM)) begin
               aux_nxt[k] = operand;
            end else if (hit_cmd && (aux_cmd == CMD_ADD_AUX_SHORT_IMM)) begin
               aux_nxt[k] = aux_register[k] + short_imm;
            end else if (hit_cmd && (aux_cmd == CMD_SUB_AUX_SHORT_IMM)) begin
               aux_nxt[k] = aux_register[k] - short_imm;
            end else if (hit_mod) begin
               aux_nxt[k] = stepped;
            end else if (hit_port) begin
               aux_nxt[k] = reg_wdata;
            end
         end

         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               aux_register[k] <= `AUX_RESET;
            end else begin
               aux_register[k] <= aux_nxt[k];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Page pointer, deliberately without reset
   always_ff @(posedge ref_clk) begin
      if (instr_valid && (aux_cmd == CMD_LOAD_PAGE_SHORT_IMM)) begin
         data_page_pointer_r <= operand[8:0];
      end else if (reg_wr && (reg_addr == `OFS_PAGE)) begin
         data_page_pointer_r <= reg_wdata[8:0];
      end
   end

   // ==========================================================
   // Auxiliary register pointer
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         aux_reg_pointer_r <= `PTR_RESET;
      end else if (pointer_en) begin
         aux_reg_pointer_r <= next_pointer;
      end else if (reg_wr && (reg_addr == `OFS_POINTER)) begin
         aux_reg_pointer_r <= reg_wdata[2:0];
      end
   end

   // ==========================================================
   // Address output, old register value before the step lands
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         data_addr_r     <= `ADDR_RESET;
         addr_valid_r    <= 1'b0;
         addr_indirect_r <= 1'b0;
      end else begin
         addr_valid_r    <= issue;
         addr_indirect_r <= issue && is_indirect;
         if (issue && is_indirect) begin
            data_addr_r <= cur_value;
         end else if (issue) begin
            data_addr_r <= {data_page_pointer_r, page_offset};
         end
      end
   end

   // ==========================================================
   // Mode error only for a branch operand that selects the forbidden direct mode
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_error_r <= 1'b0;
      end else begin
         mode_error_r <= instr_valid && !addr_use && !modify_only_op &&
                         (op_class == CLASS_BRANCH);
      end
   end

   // ==========================================================
   // Register port read
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata_r <= `AUX_RESET;
      end else if (!reg_rd) begin
         reg_rdata_r <= `AUX_RESET;
      end else if (reg_addr <= `OFS_AUX_LAST) begin
         reg_rdata_r <= aux_register[reg_addr[2:0]];
      end else if (reg_addr == `OFS_PAGE) begin
         reg_rdata_r <= {7'h00, data_page_pointer_r};
      end else if (reg_addr == `OFS_POINTER) begin
         reg_rdata_r <= {13'h0000, aux_reg_pointer_r};
      end else begin
         reg_rdata_r <= `AUX_RESET;
      end
   end

   assign reg_rdata       = reg_rdata_r;
   assign data_addr       = data_addr_r;
   assign addr_valid      = addr_valid_r;
   assign addr_indirect   = addr_indirect_r;
   assign mode_error      = mode_error_r;
   assign aux_reg_pointer = aux_reg_pointer_r;

endmodule

// ### testbench/dag_chk.sv
// Port-level assertions of the data address generator
`timescale 1ns/1ps
module dag_chk
   import dag_pkg::*;
(
   input wire logic        ref_clk,         // Core clock
   input wire logic        arst_n,          // Reset, active low
   input wire logic        instr_valid,     // Instruction strobe
   input wire logic [15:0] instr_word,      // Instruction word
   input wire op_class_t   op_class,        // Operand class
   input wire aux_cmd_t    aux_cmd,         // Aux command
   input wire logic        reg_wr,          // Port write strobe
   input wire logic        reg_rd,          // Port read strobe
   input wire logic [3:0]  reg_addr,        // Port address
   input wire logic [15:0] reg_rdata,       // Port read data
   input wire logic [15:0] data_addr,       // Issued address
   input wire logic        addr_valid,      // Address strobe
   input wire logic        addr_indirect,   // Indirect flag
   input wire logic        mode_error,      // Mode fault pulse
   input wire logic [2:0]  aux_reg_pointer  // Current pointer
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   logic mem_op;
   assign mem_op = instr_valid && op_class == CLASS_MEMORY && aux_cmd == CMD_NONE;
   // ==========================================
   // Address issue
   property p_direct;
      mem_op && !instr_word[7] |=> addr_valid && !addr_indirect
         && data_addr[6:0] == $past(instr_word[6:0]);
   endproperty
   a_direct: assert property (p_direct) else $error("direct address wrong");
   property p_indirect;
      mem_op && instr_word[7] |=> addr_valid && addr_indirect;
   endproperty
   a_indirect: assert property (p_indirect) else $error("indirect not issued");
   property p_refused;
      instr_valid && op_class inside {CLASS_IMMEDIATE, CLASS_NONE} |=> !addr_valid && !mode_error;
   endproperty
   a_refused: assert property (p_refused) else $error("refused class issued");
   property p_branch;
      instr_valid && op_class == CLASS_BRANCH && !instr_word[7] |=> mode_error && !addr_valid;
   endproperty
   a_branch: assert property (p_branch) else $error("branch direct not flagged");
   property p_cause;
      addr_valid |-> $past(instr_valid);
   endproperty
   a_cause: assert property (p_cause) else $error("address without instruction");
   // ==========================================
   // Pointer and port
   property p_ptr_load;
      mem_op && instr_word[7] && instr_word[3] |=> aux_reg_pointer == $past(instr_word[2:0]);
   endproperty
   a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");
   property p_ptr_keep;
      !(instr_valid && instr_word[7] && instr_word[3]) && !reg_wr |=> $stable(aux_reg_pointer);
   endproperty
   a_ptr_keep: assert property (p_ptr_keep) else $error("pointer changed");
   property p_unmapped;
      reg_rd && reg_addr > 4'h9 |=> reg_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind data_address_generator dag_chk u_dag_chk (.ref_clk(ref_clk), .arst_n(arst_n),
   .instr_valid(instr_valid), .instr_word(instr_word), .op_class(op_class), .aux_cmd(aux_cmd),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
   .data_addr(data_addr), .addr_valid(addr_valid), .addr_indirect(addr_indirect),
   .mode_error(mode_error), .aux_reg_pointer(aux_reg_pointer));

// ### testbench/mem_bus_model.sv
// Data memory bus model that counts every issued address and keeps the last one
`timescale 1ns/1ps
module mem_bus_model (
   input  wire logic        ref_clk,    // Core clock
   input  wire logic        addr_valid, // Address strobe
   input  wire logic [15:0] data_addr,  // Address bus
   output logic      [15:0] last_addr,  // Last address taken
   output int               n_access    // Accesses taken
);
   // One process owns the count, the port only mirrors it
   int count_r = 0;
   always @(posedge ref_clk) begin
      if (addr_valid === 1'b1) begin
         last_addr <= data_addr;
         count_r   <= count_r + 1;
      end
   end
   assign n_access = count_r;
endmodule

// ### testbench/test_data_address_generator.sv
// Self-checking bench of the data address generator
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_mismatch++; \
   $display("unexpected %s expected %h seen %h", n, e, s); end end
module test_data_address_generator;
   import dag_pkg::*;
   logic        ref_clk = 0, arst_n = 0, instr_valid = 0, reg_wr = 0, reg_rd = 0;
   logic [15:0] instr_word = 16'h0000, operand = 16'h0000, reg_wdata = 16'h0000;
   op_class_t   op_class = CLASS_MEMORY;
   aux_cmd_t    aux_cmd = CMD_NONE;
   logic [2:0]  aux_sel = 3'h2;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_rdata, data_addr, last_addr;
   logic        addr_valid, addr_indirect, mode_error;
   logic [2:0]  aux_reg_pointer;
   int          n_mismatch = 0, cmp_count = 0, n_access;
   // Step code beside the register value it leaves (base 0006, index 000c)
   logic [18:0] rows [8] = '{{3'h0, 16'h0006}, {3'h1, 16'h0005}, {3'h2, 16'h0007},
      {3'h3, 16'h0006}, {3'h4, 16'h000c}, {3'h5, 16'hfffa}, {3'h6, 16'h0012}, {3'h7, 16'h0009}};
   // Command, operand and resulting register value
   logic [34:0] cmds [5] = '{{3'h1, 16'h1234, 16'h1234}, {3'h2, 16'h12ff, 16'h00ff},
      {3'h3, 16'hfff0, 16'hfff0}, {3'h4, 16'h0020, 16'h0010}, {3'h5, 16'h0011, 16'hffff}};
   data_address_generator u_data_address_generator (.ref_clk(ref_clk), .arst_n(arst_n),
      .instr_valid(instr_valid), .instr_word(instr_word), .op_class(op_class),
      .aux_cmd(aux_cmd), .aux_sel(aux_sel), .operand(operand), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .data_addr(data_addr), .addr_valid(addr_valid), .addr_indirect(addr_indirect),
      .mode_error(mode_error), .aux_reg_pointer(aux_reg_pointer));
   mem_bus_model u_mem_bus_model (.ref_clk(ref_clk), .addr_valid(addr_valid),
      .data_addr(data_addr), .last_addr(last_addr), .n_access(n_access));
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic op(input logic [15:0] w, input op_class_t c, input aux_cmd_t k,
                     input logic [15:0] d);
      @(posedge ref_clk);
      instr_valid <= 1'b1;
      instr_word  <= w;
      op_class    <= c;
      aux_cmd     <= k;
      operand     <= d;
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      aux_cmd     <= CMD_NONE;
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata", e, reg_rdata)
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      rd(4'h3, 16'h0000);
      op(16'h0000, CLASS_IMMEDIATE, CMD_LOAD_PAGE_SHORT_IMM, 16'h01a5);
      op(16'h0509, CLASS_MEMORY, CMD_NONE, 16'h0000);
      `CHK("direct addr", 16'hd289, data_addr)
      `CHK("direct flag", 1'b0, addr_indirect)
      wr(4'h0, 16'h000c);
      wr(4'h9, 16'h0001);
      foreach (rows[i]) begin
         wr(4'h1, 16'h0006);
         op({8'h08, 1'b1, rows[i][18:16], 4'h0}, CLASS_MEMORY, CMD_NONE, 16'h0000);
         `CHK("indirect addr", 16'h0006, data_addr)
         `CHK("indirect flag", 1'b1, addr_indirect)
         rd(4'h1, rows[i][15:0]);
      end
      $display("step codes done");
      wr(4'h1, 16'h0020);
      op(16'h08ab, CLASS_MEMORY, CMD_NONE, 16'h0000);
      `CHK("old pointer addr", 16'h0020, data_addr)
      `CHK("pointer load", 3'h3, aux_reg_pointer)
      rd(4'h1, 16'h0021);
      wr(4'h3, 16'hffff);
      op(16'h08a0, CLASS_MEMORY, CMD_NONE, 16'h0000);
      `CHK("pointer kept", 3'h3, aux_reg_pointer)
      rd(4'h3, 16'h0000);
      op(16'h0509, CLASS_BRANCH, CMD_NONE, 16'h0000);
      `CHK("branch direct", 2'b01, {addr_valid, mode_error})
      op(16'h08a0, CLASS_BRANCH, CMD_NONE, 16'h0000);
      `CHK("branch indirect", 2'b10, {addr_valid, mode_error})
      op(16'h08a0, CLASS_IMMEDIATE, CMD_NONE, 16'h0000);
      `CHK("immediate indirect", 2'b00, {addr_valid, mode_error})
      rd(4'h3, 16'h0001);
      op(16'h009d, CLASS_NONE, CMD_MODIFY_ONLY_OP, 16'h0000);
      `CHK("modify only", 3'h5, aux_reg_pointer)
      rd(4'h3, 16'h0000);
      foreach (cmds[i]) begin
         op(16'h0000, CLASS_IMMEDIATE, aux_cmd_t'(cmds[i][34:32]), cmds[i][31:16]);
         rd(4'h2, cmds[i][15:0]);
      end
      wr(4'hc, 16'hbeef);
      rd(4'hc, 16'h0000);
      $display("awkward cases done");
      @(posedge ref_clk);
      arst_n <= 1'b0;
      @(posedge ref_clk);
      arst_n <= 1'b1;
      #1;
      `CHK("pointer after reset", 3'h0, aux_reg_pointer)
      rd(4'h2, 16'h0000);
      op(16'h0509, CLASS_MEMORY, CMD_NONE, 16'h0000);
      `CHK("page kept over reset", 16'hd289, data_addr)
      @(posedge ref_clk);
      #1;
      `CHK("bus accesses", 13, n_access)
      `CHK("bus last address", 16'hd289, last_addr)
      $display("reset cases done");
      report_and_stop();
   end
endmodule
